// ===== core/ras_pkg.sv
package ras_pkg;
    localparam int ADDR_W = 21;
    localparam int PTR_W = 5;
    localparam int DEPTH = 31;
    localparam logic [4:0] PTR_MAX = 5'h1F;
    localparam logic [4:0] PTR_EMPTY = 5'h00;
    // register byte addresses on apb
    localparam logic [11:0] OFF_PTR_STATUS = 12'h000;
    localparam logic [11:0] OFF_TOP_LOW = 12'h004;
    localparam logic [11:0] OFF_TOP_HIGH = 12'h008;
    localparam logic [11:0] OFF_TOP_UPPER = 12'h00C;
    localparam logic [11:0] OFF_CONFIG = 12'h010;
    // pointer/status and config field positions
    localparam int BIT_FULL = 7;
    localparam int BIT_UNDER = 6;
    localparam int BIT_FAULT_RST_EN = 0;
    localparam logic [7:0] PTR_STATUS_RESET = 8'h00;
    localparam logic CONFIG_RESET = 1'b1;
    localparam logic [20:0] PC_STEP = 21'h000002;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } ras_ctx_t;

    typedef struct packed {
        logic push;
        logic pop;
        logic fast;
        logic intAck;
        logic fastCall;
    } ras_op_t;
endpackage

// ===== core/ras_stack.sv
`timescale 1ns/1ps
`default_nettype none
module ras_stack
    import ras_pkg::*;
#(
    parameter int ENTRIES = DEPTH
) (
    // clock and resets
    input wire logic clk,
    input wire logic rst_b,
    input wire logic porRst_b,
    input wire logic clkEn,
    // core sequencer
    input wire ras_op_t op,
    input wire logic [20:0] programCounter,
    input wire ras_ctx_t liveCtx,
    // core results
    output logic [20:0] popAddr,
    output logic popValid,
    output ras_ctx_t restoreCtx,
    output logic restoreValid,
    output logic faultReset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    logic [20:0] stackMem [1:ENTRIES];
    logic [4:0] ptr_q;
    logic fullFlag_q;
    logic underFlag_q;
    logic faultRstEn_q;
    ras_ctx_t shadow_q;
    logic pendingReset_q;

    // ----------------------------------------
    // decoding
    // ----------------------------------------
    wire logic apbWr = psel && penable && pwrite && pready;
    wire logic apbRd = psel && !pwrite;
    wire logic selPtr = (paddr == OFF_PTR_STATUS);
    wire logic selLow = (paddr == OFF_TOP_LOW);
    wire logic selHigh = (paddr == OFF_TOP_HIGH);
    wire logic selUpper = (paddr == OFF_TOP_UPPER);
    wire logic selCfg = (paddr == OFF_CONFIG);
    wire logic mapped = selPtr | selLow | selHigh | selUpper | selCfg;
    wire logic hwOp = op.push | op.pop;
    wire logic swWrOk = apbWr && pstrb[0] && !hwOp;
    wire logic atFull = (ptr_q == PTR_MAX);
    wire logic atEmpty = (ptr_q == PTR_EMPTY);
    wire logic pushTo31 = op.push && (ptr_q == PTR_MAX - 5'h01);
    wire logic [4:0] ptrInc = ptr_q + 5'h01;
    wire logic [4:0] ptrDec = ptr_q - 5'h01;
    wire logic [20:0] topEntry = atEmpty ? 21'h000000 : stackMem[ptr_q];
    wire logic [7:0] statusByte = {fullFlag_q, underFlag_q, 1'b0, ptr_q};
    wire logic [20:0] pushValue = (pushTo31 && faultRstEn_q) ? programCounter + PC_STEP
                                                               : programCounter;
    wire logic [31:0] rdMux = selPtr ? {24'h000000, statusByte} :
                              selLow ? {24'h000000, topEntry[7:0]} :
                              selHigh ? {24'h000000, topEntry[15:8]} :
                              selUpper ? {27'h0000000, topEntry[20:16]} :
                              selCfg ? {31'h00000000, faultRstEn_q} : 32'h00000000;

    // ----------------------------------------
    // stack memory
    // ----------------------------------------
    // pushes never land on slot 31 once full, so a stuck stack keeps its last return
    always_ff @(posedge clk) begin
        if (clkEn) begin
            if (op.push && !atFull) begin
                stackMem[ptrInc] <= pushValue;
            end else if (swWrOk && !atEmpty && selLow) begin
                stackMem[ptr_q][7:0] <= pwdata[7:0];
            end else if (swWrOk && !atEmpty && selHigh) begin
                stackMem[ptr_q][15:8] <= pwdata[7:0];
            end else if (swWrOk && !atEmpty && selUpper) begin
                stackMem[ptr_q][20:16] <= pwdata[4:0];
            end
        end
    end

    // ----------------------------------------
    // pointer: cleared by rst_b and by a fault reset
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_q <= PTR_EMPTY;
        end else if (clkEn) begin
            if (pendingReset_q) begin
                ptr_q <= PTR_EMPTY;
            end else if (op.push) begin
                ptr_q <= atFull ? ptr_q : ptrInc;
            end else if (op.pop) begin
                ptr_q <= atEmpty ? ptr_q : ptrDec;
            end else if (swWrOk && selPtr) begin
                ptr_q <= pwdata[4:0];
            end
        end
    end

    // ----------------------------------------
    // sticky flags: power-on reset only
    // ----------------------------------------
    // set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge porRst_b) begin
        if (!porRst_b) begin
            fullFlag_q <= 1'b0;
            underFlag_q <= 1'b0;
            faultRstEn_q <= CONFIG_RESET;
        end else if (clkEn) begin
            if (pushTo31 || (op.push && atFull)) begin
                fullFlag_q <= 1'b1;
            end else if (apbWr && pstrb[0] && selPtr && !pwdata[BIT_FULL]) begin
                fullFlag_q <= 1'b0;
            end
            if (op.pop && atEmpty) begin
                underFlag_q <= 1'b1;
            end else if (apbWr && pstrb[0] && selPtr && !pwdata[BIT_UNDER]) begin
                underFlag_q <= 1'b0;
            end
            if (apbWr && pstrb[0] && selCfg) begin
                faultRstEn_q <= pwdata[BIT_FAULT_RST_EN];
            end
        end
    end

    // ----------------------------------------
    // core results, shadow context, fault reset
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            popAddr <= 21'h000000;
            popValid <= 1'b0;
            restoreCtx <= '0;
            restoreValid <= 1'b0;
            shadow_q <= '0;
            pendingReset_q <= 1'b0;
            faultReset <= 1'b0;
        end else if (clkEn) begin
            popValid <= op.pop;
            popAddr <= op.pop ? topEntry : popAddr;
            if (op.intAck || op.fastCall) begin
                shadow_q <= liveCtx;
            end
            restoreValid <= op.pop && op.fast;
            restoreCtx <= (op.pop && op.fast) ? shadow_q : restoreCtx;
            pendingReset_q <= faultRstEn_q && ((pushTo31) || (op.pop && atEmpty));
            faultReset <= pendingReset_q;
        end
    end

    // ----------------------------------------
    // apb slave: no wait states, errors on unmapped
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata <= (apbRd && !penable) ? rdMux : prdata;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_push_ptr_inc: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.push && !atFull && !pendingReset_q |=> ptr_q == $past(ptr_q) + 5'h01)
        else $error("push did not increment pointer");
    chk_full_hold: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.push && atFull && !pendingReset_q |=> atFull)
        else $error("pointer left 31 on push when full");
    chk_underflow_set: assert property (@(posedge clk) disable iff (!porRst_b)
        clkEn && op.pop && atEmpty |=> underFlag_q && popAddr == 21'h000000)
        else $error("empty pop did not flag underflow");
    chk_full_set: assert property (@(posedge clk) disable iff (!porRst_b)
        clkEn && pushTo31 |=> fullFlag_q)
        else $error("31st push did not set full");
    chk_fault_reset_seq: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && faultRstEn_q && op.pop && atEmpty ##1 clkEn |=> faultReset)
        else $error("fault reset missing");
    chk_no_reset_off: assert property (@(posedge clk) disable iff (!rst_b)
        !faultRstEn_q && !pendingReset_q |=> !faultReset)
        else $error("fault reset with option off");
    chk_fast_restore: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop && op.fast |=> restoreValid && restoreCtx == $past(shadow_q))
        else $error("fast return restored wrong context");
    chk_shadow_load: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.intAck |=> shadow_q == $past(liveCtx))
        else $error("interrupt did not load shadow");
    chk_status_bit5: assert property (@(posedge clk) disable iff (!rst_b)
        !statusByte[5])
        else $error("status bit 5 not zero");

    // ----------------------------------------
    // checks: pointer and storage
    // ----------------------------------------
    // a plain pop walks the pointer down by one
    chk_pop_ptr_dec: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop && !op.push && !atEmpty && !pendingReset_q |=> ptr_q == $past(ptr_q) - 5'h01)
        else $error("pop did not decrement pointer");

    // an empty pop must not wrap the pointer round to 31
    chk_empty_pop_park: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop && !op.push && atEmpty && !pendingReset_q |=> atEmpty)
        else $error("empty pop moved pointer");

    // the core needs exactly one strobe per pop
    chk_pop_valid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop |=> popValid)
        else $error("pop without valid strobe");

    // no stray strobe between pops
    chk_pop_no_valid: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && !op.pop |=> !popValid)
        else $error("valid strobe without pop");

    // the entry is read before the pointer moves down
    chk_pop_top_data: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop && !atEmpty |=> popAddr == $past(stackMem[ptr_q]))
        else $error("pop returned wrong entry");

    // an ordinary push lands the pc in the freshly opened slot
    chk_push_store_pc: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.push && !atFull && !pushTo31 && !pendingReset_q |=>
            stackMem[ptr_q] == $past(programCounter))
        else $error("push stored wrong pc");

    // the fatal push leaves the following address behind for the handler
    chk_push_pc_plus2: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && pushTo31 && faultRstEn_q |=> stackMem[PTR_MAX] == $past(programCounter) + PC_STEP)
        else $error("fatal push did not store pc plus step");

    // without the option the last slot takes the plain pc
    chk_push_plain_pc: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && pushTo31 && !faultRstEn_q |=> stackMem[PTR_MAX] == $past(programCounter))
        else $error("last push stored wrong pc");

    // a stuck stack keeps the last pushed return in slot 31
    chk_full_keeps_slot: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.push && atFull |=> stackMem[PTR_MAX] == $past(stackMem[PTR_MAX]))
        else $error("push overwrote slot 31");

    chk_full_ptr_31: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && pushTo31 && !pendingReset_q |=> atFull)
        else $error("31st push did not reach 31");

    // ----------------------------------------
    // checks: fault reset, software access, context
    // ----------------------------------------
    // the device reset request also parks the pointer
    chk_fault_ptr_zero: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && pendingReset_q |=> atEmpty)
        else $error("fault reset left pointer set");

    chk_fault_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && pendingReset_q |=> faultReset)
        else $error("armed fault reset not issued");

    chk_fault_arm_full: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && faultRstEn_q && pushTo31 |=> pendingReset_q)
        else $error("fatal push did not arm reset");

    // vectoring to zero on underflow is not a reset when the option is off
    chk_under_no_reset: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && !faultRstEn_q && op.pop && atEmpty |=> !pendingReset_q)
        else $error("underflow armed reset with option off");

    // an idle cycle lets software steer the pointer
    chk_ptr_sw_write: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && swWrOk && selPtr && !pendingReset_q |=> ptr_q == $past(pwdata[4:0]))
        else $error("software pointer write lost");

    // a racing software write must not undo the hardware push
    chk_hw_beats_sw: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.push && !atFull && !pendingReset_q && apbWr && selPtr |=>
            ptr_q == $past(ptr_q) + 5'h01)
        else $error("software write beat push");

    // pop does not write storage, so a racing top write must vanish too
    chk_hw_beats_top: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.pop && !atEmpty && apbWr && (selLow || selHigh || selUpper) |=>
            stackMem[$past(ptr_q)] == $past(stackMem[ptr_q]))
        else $error("software top write beat pop");

    // flags survive everything but a software clear or power-on
    chk_full_sticky: assert property (@(posedge clk) disable iff (!porRst_b)
        fullFlag_q && !(apbWr && pstrb[0] && selPtr && !pwdata[BIT_FULL]) |=> fullFlag_q)
        else $error("full flag dropped by itself");

    chk_under_sticky: assert property (@(posedge clk) disable iff (!porRst_b)
        underFlag_q && !(apbWr && pstrb[0] && selPtr && !pwdata[BIT_UNDER]) |=> underFlag_q)
        else $error("underflow flag dropped by itself");

    chk_flags_por: assert property (@(posedge clk) disable iff (!porRst_b)
        $rose(porRst_b) |-> !fullFlag_q && !underFlag_q)
        else $error("flags set after power-on");

    chk_ptr_after_reset: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> atEmpty)
        else $error("pointer not zero after reset");

    chk_fast_call_shadow: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.fastCall |=> shadow_q == $past(liveCtx))
        else $error("fast call did not load shadow");

    // a later interrupt simply overwrites the single level
    chk_nested_shadow: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && op.intAck ##1 clkEn && op.intAck |=> shadow_q == $past(liveCtx))
        else $error("nested interrupt kept old shadow");

    // software has no path into the shadow copies
    chk_shadow_hold: assert property (@(posedge clk) disable iff (!rst_b)
        !(clkEn && (op.intAck || op.fastCall)) |=> $stable(shadow_q))
        else $error("shadow changed without vectoring");

    chk_restore_only_fast: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && !(op.pop && op.fast) |=> !restoreValid)
        else $error("restore without fast return");

    chk_upper_read_pad: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && apbRd && !penable && selUpper |=> prdata[31:5] == 27'h0000000)
        else $error("upper byte read not padded");

    chk_status_read: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && apbRd && !penable && selPtr |=> !prdata[5] && prdata[4:0] == $past(ptr_q))
        else $error("status read wrong pointer field");

    chk_status_flags_read: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && apbRd && !penable && selPtr |=>
            prdata[BIT_FULL] == $past(fullFlag_q) && prdata[BIT_UNDER] == $past(underFlag_q))
        else $error("status read wrong flags");

    // slot zero has no storage, so the top reads as zero there
    chk_empty_top_zero: assert property (@(posedge clk) disable iff (!rst_b)
        clkEn && apbRd && !penable && selLow && atEmpty |=> prdata == 32'h00000000)
        else $error("empty stack top not zero");

endmodule
`default_nettype wire

// ===== tb/ras_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ras_core_model
    import ras_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // bench requests
    input wire ras_op_t req,
    // core side of the stack
    output ras_op_t op,
    output logic [20:0] programCounter,
    output ras_ctx_t liveCtx
);
    // -----------------------------
    // sequencer: one-cycle op pulses
    // -----------------------------
    // pc already points past the call when it is pushed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op <= '0;
            programCounter <= 21'h000100;
            liveCtx <= 24'h123456;
        end else begin
            op <= req;
            if (op.push) programCounter <= programCounter + PC_STEP;
            if (op.intAck || op.fastCall) liveCtx <= liveCtx + 24'h111111;
        end
    end
endmodule
`default_nettype wire

// ===== tb/return_address_stack_tb.sv
`timescale 1ns/1ps
`default_nettype none
module return_address_stack_tb
    import ras_pkg::*;
;
    logic clk, rst_b, porRst_b, psel, penable, pwrite, popValid, restoreValid, faultReset;
    logic pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [20:0] programCounter, popAddr, pcA;
    ras_op_t req, op;
    ras_ctx_t liveCtx, restoreCtx, ctxA;
    int failures = 0;
    int n_tests = 0;
    int nFault = 0;

    ras_core_model core_u (.clk(clk), .rst_b(rst_b), .req(req), .op(op),
        .programCounter(programCounter), .liveCtx(liveCtx));
    ras_stack dut_u (.clk(clk), .rst_b(rst_b), .porRst_b(porRst_b), .clkEn(1'b1), .op(op),
        .programCounter(programCounter), .liveCtx(liveCtx), .popAddr(popAddr),
        .popValid(popValid), .restoreCtx(restoreCtx), .restoreValid(restoreValid),
        .faultReset(faultReset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (faultReset === 1'b1) nFault++;

    // -----------------------------
    // shared tasks
    // -----------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (n == 19) begin failures++; give_verdict(); end
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic core(input ras_op_t o);
        req <= o;
        @(posedge clk);
        req <= '0;
        repeat (5) @(posedge clk);
    endtask
    task automatic resets(input logic por);
        rst_b <= 1'b0; porRst_b <= !por;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1; porRst_b <= 1'b1;
        @(posedge clk);
    endtask

    // -----------------------------
    // scenarios
    // -----------------------------
    task automatic sc_push_pop();
        core(5'b10000);
        pcA = programCounter;
        core(5'b10000);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("ptr", rd, 32'h02);
        apb(1'b0, OFF_TOP_LOW, 32'h0); chk("toplow", rd[7:0], pcA[7:0]);
        apb(1'b0, OFF_TOP_HIGH, 32'h0); chk("tophigh", rd[7:0], pcA[15:8]);
        apb(1'b0, OFF_TOP_UPPER, 32'h0); chk("topup", rd[7:0], {3'h0, pcA[20:16]});
        core(5'b01000); chk("popaddr", popAddr, pcA);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("ptrpop", rd, 32'h01);
        apb(1'b1, OFF_PTR_STATUS, 32'h3B); apb(1'b0, OFF_PTR_STATUS, 32'h0);
        chk("ptrwr", rd, 32'h1B);
        apb(1'b0, 12'h0F0, 32'h0); chk("unmapped", err, 32'h1);
        chk("unmrd", rd, 32'h0);
    endtask
    task automatic sc_underflow();
        apb(1'b1, OFF_CONFIG, 32'h0); apb(1'b1, OFF_PTR_STATUS, 32'h0);
        core(5'b01000); chk("unfaddr", popAddr, 32'h0);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("unf", rd, 32'h40);
        chk("nofault", nFault, 32'h0);
    endtask
    task automatic sc_full(input logic optOn);
        apb(1'b1, OFF_CONFIG, {31'h0, optOn});
        apb(1'b1, OFF_PTR_STATUS, 32'h1D);
        core(5'b10000); pcA = programCounter; core(5'b10000);
        apb(1'b0, OFF_PTR_STATUS, 32'h0);
        chk("full", rd, optOn ? 32'h80 : 32'h9F);
        chk("faultcnt", nFault, {31'h0, optOn});
        if (!optOn) begin
            core(5'b10000);
            apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("stay31", rd, 32'h9F);
            apb(1'b0, OFF_TOP_LOW, 32'h0); chk("keep31", rd[7:0], pcA[7:0]);
        end else begin
            core(5'b01000);
            chk("unffault", nFault, 32'h2);
            apb(1'b1, OFF_PTR_STATUS, 32'hDF);
            apb(1'b0, OFF_TOP_LOW, 32'h0);
            pcA = pcA + PC_STEP;
            chk("pcstep", rd[7:0], pcA[7:0]);
        end
    endtask
    task automatic sc_shadow();
        ctxA = liveCtx;
        core(5'b00010); core(5'b00010);
        core(5'b01100); chk("fastret", restoreCtx, ctxA + 24'h111111);
        ctxA = liveCtx;
        core(5'b00001); core(5'b01100); chk("fastcall", restoreCtx, ctxA);
    endtask

    initial begin
        rst_b = 1'b0; porRst_b = 1'b0; req = '0;
        psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1; porRst_b <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("rststat", rd, 32'h00);
        apb(1'b0, OFF_CONFIG, 32'h0); chk("rstcfg", rd, 32'h1);
        sc_push_pop();
        sc_shadow();
        sc_underflow();
        apb(1'b1, OFF_PTR_STATUS, 32'h45);
        resets(1'b0);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("sticky", rd, 32'h40);
        sc_full(1'b0);
        apb(1'b1, OFF_PTR_STATUS, 32'h00);
        sc_full(1'b1);
        resets(1'b1);
        apb(1'b0, OFF_PTR_STATUS, 32'h0); chk("por", rd, 32'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
